//--- core/ptid_pkg.sv
// package: register map, field layout and reset values of the pci target window decoder
package ptid_pkg;
	localparam logic [11:0] OFF_IMG0_BOUND  = 12'h108;
	localparam logic [11:0] OFF_IMG0_XLATE  = 12'h10c;
	localparam logic [11:0] OFF_IMG1_CTRL   = 12'h114;
	localparam logic [11:0] OFF_IMG1_BASE   = 12'h118;
	localparam logic [11:0] OFF_IMG1_BOUND  = 12'h11c;
	localparam logic [11:0] OFF_IMG1_XLATE  = 12'h120;
	localparam logic [11:0] OFF_IMG2_CTRL   = 12'h128;
	localparam logic [11:0] OFF_IMG2_BASE   = 12'h12c;
	localparam logic [11:0] OFF_IMG2_BOUND  = 12'h130;
	localparam logic [11:0] OFF_IMG2_XLATE  = 12'h134;
	// control register bit positions
	localparam int POS_EN    = 31;
	localparam int POS_POST  = 30;
	localparam int POS_WIDTH = 22;
	localparam int POS_SPACE = 16;
	localparam int POS_PROG  = 14;
	localparam int POS_SUPER = 12;
	localparam int POS_BLOCK = 8;
	localparam int POS_IOSEL = 0;
	// writable bits of a control register; all others read zero
	localparam logic [31:0] CTRL_MASK   = 32'hc0c7_5101;
	localparam logic [31:0] CTRL_RESET  = 32'h0080_0000;
	localparam logic [31:0] ADDR_RESET  = 32'h0000_0000;
	localparam logic [31:0] MASK_4K     = 32'hffff_f000;
	localparam logic [31:0] MASK_64K    = 32'hffff_0000;
	// window 0 base and control are strapped outside this block
	localparam logic [31:0] IMG0_BASE_DFLT = 32'h0000_0000;
	localparam logic [31:0] IMG0_CTRL_DFLT = 32'h0080_0000;
	localparam logic [1:0] WIDTH_D64 = 2'h3;
	localparam logic [2:0] SPACE_A24 = 3'h1;
	localparam logic [2:0] SPACE_A32 = 3'h2;
	typedef enum logic [2:0] {
		PTID_XF_SINGLE = 3'b001,
		PTID_XF_BLT    = 3'b010,
		PTID_XF_MBLT   = 3'b100
	} ptid_xfer_t;
endpackage : ptid_pkg

//--- core/ptid_window.sv
// one target window: range compare, translation and cycle attributes
`timescale 1ns/1ns
`default_nettype none
module ptid_window #(
	parameter int LSB = 16
) (
	input  wire logic [31:0] pciAddr,     // incoming pci address
	input  wire logic        pciIo,       // 1 for an i/o-space access
	input  wire logic [31:0] baseAddr,    // window base
	input  wire logic [31:0] boundAddr,   // window bound, zero for no limit
	input  wire logic [31:0] xlateOff,    // translation offset
	input  wire logic [31:0] ctrl,        // control word
	output logic             hit,         // window claims the address
	output logic [31:0]      vmeAddr,     // translated address
	output logic             posted,      // write is posted
	output ptid_pkg::ptid_xfer_t xferKind // transfer kind
);
	import ptid_pkg::*;
	logic [31-LSB:0] a;
	logic [31-LSB:0] b;
	logic [31-LSB:0] bnd;
	logic [2:0]      spc;
	logic [1:0]      wid;
	logic            wideSpace;
	always_comb begin
		a  = pciAddr[31:LSB];
		b  = baseAddr[31:LSB];
		bnd = boundAddr[31:LSB];
		spc = ctrl[POS_SPACE +: 3];
		wid = ctrl[POS_WIDTH +: 2];
		wideSpace = (spc == SPACE_A24) || (spc == SPACE_A32);
		hit = ctrl[POS_EN] && (pciIo == ctrl[POS_IOSEL])
			&& (a >= b) && ((bnd == '0) || (a < bnd));
		// carry out of the sum is dropped by the width of the target
		vmeAddr = {a + xlateOff[31:LSB], pciAddr[LSB-1:0]};
		// i/o accesses are never posted
		posted = ctrl[POS_POST] && !ctrl[POS_IOSEL];
		if (wideSpace && wid == WIDTH_D64) begin
			xferKind = PTID_XF_MBLT;
		end else if (wideSpace && ctrl[POS_BLOCK]) begin
			xferKind = PTID_XF_BLT;
		end else begin
			xferKind = PTID_XF_SINGLE;
		end
	end
endmodule : ptid_window
`default_nettype wire

//--- core/ptid_regs.sv
// one masked read/write register with synchronous reset
`timescale 1ns/1ns
`default_nettype none
module ptid_regs #(
	parameter logic [31:0] MASK = 32'hffff_ffff,
	parameter logic [31:0] RST  = 32'h0000_0000
) (
	input  wire logic        sys_clk, // clock
	input  wire logic        rst_n,   // sync reset, active low
	input  wire logic        wrEn,    // write strobe for this register
	input  wire logic [31:0] wrData,  // write data
	output logic      [31:0] value    // stored value
);
	logic [31:0] value_q;
	logic [31:0] value_d;
	always_comb begin
		value_d = wrEn ? (wrData & MASK) : value_q;
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			value_q <= RST;
		end else begin
			value_q <= value_d;
		end
	end
	assign value = value_q;
endmodule : ptid_regs
`default_nettype wire

//--- core/ptid_decode.sv
// target window decoder top: register file, three windows, priority select
`timescale 1ns/1ns
`default_nettype none
module ptid_decode (
	input  wire logic        sys_clk,     // clock, 20 MHz
	input  wire logic        rst_n,       // sync reset, active low
	input  wire logic        regWr,       // register write strobe
	input  wire logic        regRd,       // register read strobe
	input  wire logic [11:0] regAddr,     // register byte offset
	input  wire logic [31:0] regWdata,    // register write data
	output logic      [31:0] regRdata,    // register read data
	input  wire logic [31:0] img0Base,    // window 0 base, held outside
	input  wire logic [31:0] img0Ctrl,    // window 0 control, held outside
	input  wire logic        pciValid,    // address phase present
	input  wire logic [31:0] pciAddr,     // pci address
	input  wire logic        pciIo,       // 1 for i/o space access
	output logic             claim,       // some window claims the access
	output logic [1:0]       imageSel,    // claiming window
	output logic [31:0]      vmeAddr,     // translated vme address
	output logic             posted,      // posted write
	output logic [1:0]       vmeWidth,    // max data width code
	output logic [2:0]       vmeSpace,    // vme address space code
	output logic             programAm,   // program modifier selected
	output logic             superAm,     // supervisor modifier selected
	output ptid_pkg::ptid_xfer_t xferKind,// transfer kind
	output logic             spaceBad     // reserved space code in claiming window
);
	import ptid_pkg::*;
	localparam int NW = 3;
	localparam logic [31:0] CTRL_WMASK = CTRL_MASK;

	logic [31:0] bound0, xlate0;
	logic [31:0] ctl1, base1, bound1, xlate1;
	logic [31:0] ctl2, base2, bound2, xlate2;
	logic [31:0] rd_d, rd_q;

	ptid_regs #(.MASK(MASK_4K), .RST(ADDR_RESET)) u_bnd0 (
		.sys_clk(sys_clk), .rst_n(rst_n), .wrEn(regWr && regAddr == OFF_IMG0_BOUND),
		.wrData(regWdata), .value(bound0));
	ptid_regs #(.MASK(MASK_4K), .RST(ADDR_RESET)) u_to0 (
		.sys_clk(sys_clk), .rst_n(rst_n), .wrEn(regWr && regAddr == OFF_IMG0_XLATE),
		.wrData(regWdata), .value(xlate0));
	ptid_regs #(.MASK(CTRL_WMASK), .RST(CTRL_RESET)) u_ct1 (
		.sys_clk(sys_clk), .rst_n(rst_n), .wrEn(regWr && regAddr == OFF_IMG1_CTRL),
		.wrData(regWdata), .value(ctl1));
	ptid_regs #(.MASK(MASK_64K), .RST(ADDR_RESET)) u_base1 (
		.sys_clk(sys_clk), .rst_n(rst_n), .wrEn(regWr && regAddr == OFF_IMG1_BASE),
		.wrData(regWdata), .value(base1));
	ptid_regs #(.MASK(MASK_64K), .RST(ADDR_RESET)) u_bnd1 (
		.sys_clk(sys_clk), .rst_n(rst_n), .wrEn(regWr && regAddr == OFF_IMG1_BOUND),
		.wrData(regWdata), .value(bound1));
	ptid_regs #(.MASK(MASK_64K), .RST(ADDR_RESET)) u_to1 (
		.sys_clk(sys_clk), .rst_n(rst_n), .wrEn(regWr && regAddr == OFF_IMG1_XLATE),
		.wrData(regWdata), .value(xlate1));
	ptid_regs #(.MASK(CTRL_WMASK), .RST(CTRL_RESET)) u_ct2 (
		.sys_clk(sys_clk), .rst_n(rst_n), .wrEn(regWr && regAddr == OFF_IMG2_CTRL),
		.wrData(regWdata), .value(ctl2));
	ptid_regs #(.MASK(MASK_64K), .RST(ADDR_RESET)) u_base2 (
		.sys_clk(sys_clk), .rst_n(rst_n), .wrEn(regWr && regAddr == OFF_IMG2_BASE),
		.wrData(regWdata), .value(base2));
	ptid_regs #(.MASK(MASK_64K), .RST(ADDR_RESET)) u_bnd2 (
		.sys_clk(sys_clk), .rst_n(rst_n), .wrEn(regWr && regAddr == OFF_IMG2_BOUND),
		.wrData(regWdata), .value(bound2));
	ptid_regs #(.MASK(MASK_64K), .RST(ADDR_RESET)) u_to2 (
		.sys_clk(sys_clk), .rst_n(rst_n), .wrEn(regWr && regAddr == OFF_IMG2_XLATE),
		.wrData(regWdata), .value(xlate2));

	// read mux; unmapped offsets return zero
	always_comb begin
		case (regAddr)
			OFF_IMG0_BOUND: rd_d = bound0;
			OFF_IMG0_XLATE: rd_d = xlate0;
			OFF_IMG1_CTRL:  rd_d = ctl1;
			OFF_IMG1_BASE:  rd_d = base1;
			OFF_IMG1_BOUND: rd_d = bound1;
			OFF_IMG1_XLATE: rd_d = xlate1;
			OFF_IMG2_CTRL:  rd_d = ctl2;
			OFF_IMG2_BASE:  rd_d = base2;
			OFF_IMG2_BOUND: rd_d = bound2;
			OFF_IMG2_XLATE: rd_d = xlate2;
			default:        rd_d = 32'h0000_0000;
		endcase
		if (!regRd) begin
			rd_d = rd_q;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rd_q <= 32'h0000_0000;
		end else begin
			rd_q <= rd_d;
		end
	end
	assign regRdata = rd_q;

	// window instances
	logic [31:0] wBase  [NW];
	logic [31:0] wBound [NW];
	logic [31:0] wXlate [NW];
	logic [31:0] wCtrl  [NW];
	logic        wHit   [NW];
	logic [31:0] wVme   [NW];
	logic        wPost  [NW];
	ptid_xfer_t  wXfer  [NW];
	always_comb begin
		wBase[0] = img0Base & MASK_4K;
		wBound[0] = bound0;
		wXlate[0] = xlate0;
		wCtrl[0] = img0Ctrl & CTRL_MASK;
		wBase[1] = base1;
		wBound[1] = bound1;
		wXlate[1] = xlate1;
		wCtrl[1] = ctl1;
		wBase[2] = base2;
		wBound[2] = bound2;
		wXlate[2] = xlate2;
		wCtrl[2] = ctl2;
	end
	genvar gi;
	generate
		for (gi = 0; gi < NW; gi++) begin : g_win
			ptid_window #(.LSB(gi == 0 ? 12 : 16)) u_win (
				.pciAddr(pciAddr), .pciIo(pciIo),
				.baseAddr(wBase[gi]), .boundAddr(wBound[gi]),
				.xlateOff(wXlate[gi]), .ctrl(wCtrl[gi]),
				.hit(wHit[gi]), .vmeAddr(wVme[gi]),
				.posted(wPost[gi]), .xferKind(wXfer[gi]));
		end
	endgenerate

	// lowest-numbered hitting window wins; overlap is a software error
	logic        claim_d, claim_q;
	logic [1:0]  sel_d, sel_q;
	logic [31:0] vme_d, vme_q;
	logic        post_d, post_q, prg_d, prg_q, sup_d, sup_q, bad_d, bad_q;
	logic [1:0]  wid_d, wid_q;
	logic [2:0]  spc_d, spc_q;
	ptid_xfer_t  xf_d, xf_q;
	logic [31:0] c;
	always_comb begin
		claim_d = 1'b0;
		sel_d = 2'h0;
		for (int i = NW - 1; i >= 0; i--) begin
			if (pciValid && wHit[i]) begin
				claim_d = 1'b1;
				sel_d = 2'(i);
			end
		end
		c = wCtrl[sel_d];
		vme_d = claim_d ? wVme[sel_d] : 32'h0000_0000;
		post_d = claim_d && wPost[sel_d];
		wid_d = c[POS_WIDTH +: 2];
		spc_d = c[POS_SPACE +: 3];
		prg_d = c[POS_PROG];
		sup_d = c[POS_SUPER];
		xf_d = claim_d ? wXfer[sel_d] : PTID_XF_SINGLE;
		// codes 011 and 100 reserved everywhere, 101 valid only on window 2
		bad_d = claim_d && ((spc_d == 3'h3) || (spc_d == 3'h4)
			|| (spc_d == 3'h5 && sel_d != 2'h2));
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			claim_q <= 1'b0;
			sel_q <= 2'h0;
			vme_q <= 32'h0000_0000;
			post_q <= 1'b0;
			wid_q <= 2'h2;
			spc_q <= 3'h0;
			prg_q <= 1'b0;
			sup_q <= 1'b0;
			xf_q <= PTID_XF_SINGLE;
			bad_q <= 1'b0;
		end else begin
			claim_q <= claim_d;
			sel_q <= sel_d;
			vme_q <= vme_d;
			post_q <= post_d;
			wid_q <= wid_d;
			spc_q <= spc_d;
			prg_q <= prg_d;
			sup_q <= sup_d;
			xf_q <= xf_d;
			bad_q <= bad_d;
		end
	end
	assign claim = claim_q;
	assign imageSel = sel_q;
	assign vmeAddr = vme_q;
	assign posted = post_q;
	assign vmeWidth = wid_q;
	assign vmeSpace = spc_q;
	assign programAm = prg_q;
	assign superAm = sup_q;
	assign xferKind = xf_q;
	assign spaceBad = bad_q;

	a_claim_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(claim && imageSel == 2'h1) |-> $past(pciAddr[31:16] >= base1[31:16]))
		else $error("window 1 claimed below base");
	a_disabled_none: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(claim && imageSel == 2'h2) |-> $past(ctl2[POS_EN]))
		else $error("disabled window 2 claimed");
	a_bound_limit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(claim && imageSel == 2'h1) |->
		$past(bound1[31:16] == 16'h0000 || pciAddr[31:16] < bound1[31:16]))
		else $error("window 1 claimed at or above bound");
	a_xlate_sum: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(claim && imageSel == 2'h2) |->
		vmeAddr[31:16] == 16'($past(pciAddr[31:16]) + $past(xlate2[31:16])))
		else $error("window 2 translation wrong");
	a_io_coupled: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(claim && $past(pciIo)) |-> !posted)
		else $error("i/o access posted");
	a_space_match: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(claim && imageSel == 2'h1) |-> $past(pciIo) == $past(ctl1[POS_IOSEL]))
		else $error("window 1 claimed wrong pci space");
	a_mblt_wide: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(xferKind == PTID_XF_MBLT) |-> vmeWidth == WIDTH_D64)
		else $error("mblt without 64-bit width");
	a_blt_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(xferKind == PTID_XF_BLT) |->
		(vmeSpace == SPACE_A24 || vmeSpace == SPACE_A32) && vmeWidth != WIDTH_D64)
		else $error("block transfer outside A24/A32");
	a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$past(regRd && regAddr == OFF_IMG1_BASE) |-> regRdata[15:0] == 16'h0000)
		else $error("reserved base bits read nonzero");
endmodule : ptid_decode
`default_nettype wire

//--- verif/ptid_pci_master.sv
// pci master model: presents one address phase per call
`timescale 1ns/1ns
`default_nettype none
module ptid_pci_master (
	input  wire logic        sys_clk,  // clock
	output logic             pciValid, // address phase present
	output logic [31:0]      pciAddr,  // pci address
	output logic             pciIo     // 1 for an i/o access
);
	initial begin
		pciValid = 1'b0;
		pciAddr  = 32'h0000_0000;
		pciIo    = 1'b0;
	end
	// once released the lines show the inverse, so a stale address can never match by luck
	task automatic issue(input logic [31:0] addr, input logic io);
		@(posedge sys_clk);
		#1;
		pciValid = 1'b1;
		pciAddr  = addr;
		pciIo    = io;
		@(posedge sys_clk);
		#1;
		pciValid = 1'b0;
		pciAddr  = ~addr;
		pciIo    = ~io;
	endtask : issue
endmodule : ptid_pci_master
`default_nettype wire

//--- verif/tb.sv
// testbench: register access and window decode checks of the target window decoder
`timescale 1ns/1ns
`default_nettype none
module tb;
	import ptid_pkg::*;
	localparam logic [2:0] SGL = PTID_XF_SINGLE;
	localparam logic [11:0] OFFS [10] = '{OFF_IMG0_BOUND, OFF_IMG0_XLATE, OFF_IMG1_CTRL,
		OFF_IMG1_BASE, OFF_IMG1_BOUND, OFF_IMG1_XLATE, OFF_IMG2_CTRL, OFF_IMG2_BASE,
		OFF_IMG2_BOUND, OFF_IMG2_XLATE};
	localparam logic [31:0] MSKS [10] = '{MASK_4K, MASK_4K, CTRL_MASK, MASK_64K, MASK_64K,
		MASK_64K, CTRL_MASK, MASK_64K, MASK_64K, MASK_64K};
	logic        sys_clk;
	logic        rst_n;
	logic        regWr;
	logic        regRd;
	logic [11:0] regAddr;
	logic [31:0] regWdata;
	logic [31:0] regRdata;
	logic [31:0] img0Base;
	logic [31:0] img0Ctrl;
	logic        pciValid;
	logic [31:0] pciAddr;
	logic        pciIo;
	logic        claim;
	logic [1:0]  imageSel;
	logic [31:0] vmeAddr;
	logic        posted;
	logic [1:0]  vmeWidth;
	logic [2:0]  vmeSpace;
	logic        programAm;
	logic        superAm;
	ptid_xfer_t  xferKind;
	logic        spaceBad;
	logic [31:0] ctl;
	logic [2:0]  kind;
	int          mismatches;
	int          comparisons;
	int          i;

	ptid_decode ptid_decode_inst (.sys_clk(sys_clk), .rst_n(rst_n), .regWr(regWr),
		.regRd(regRd), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
		.img0Base(img0Base), .img0Ctrl(img0Ctrl), .pciValid(pciValid), .pciAddr(pciAddr),
		.pciIo(pciIo), .claim(claim), .imageSel(imageSel), .vmeAddr(vmeAddr),
		.posted(posted), .vmeWidth(vmeWidth), .vmeSpace(vmeSpace), .programAm(programAm),
		.superAm(superAm), .xferKind(xferKind), .spaceBad(spaceBad));
	ptid_pci_master ptid_pci_master_inst (.sys_clk(sys_clk), .pciValid(pciValid),
		.pciAddr(pciAddr), .pciIo(pciIo));

	initial sys_clk = 1'b0;
	always #25 sys_clk = ~sys_clk;

	task automatic complete_run();
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		#1;
		regWr    = 1'b1;
		regAddr  = a;
		regWdata = d;
		@(posedge sys_clk);
		#1;
		regWr = 1'b0;
	endtask : reg_wr

	// read data is registered, so it is looked at one edge after the strobe
	task automatic reg_rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		#1;
		regRd   = 1'b1;
		regAddr = a;
		@(posedge sys_clk);
		#1;
		regRd = 1'b0;
		check({32'h0, regRdata}, {32'h0, exp});
	endtask : reg_rd

	task automatic probe(input logic [31:0] a, input logic io, input logic c,
		input logic [1:0] s, input logic [31:0] v, input logic p, input logic [2:0] k);
		ptid_pci_master_inst.issue(a, io);
		check({25'h0, claim, imageSel, posted, xferKind, vmeAddr}, {25'h0, c, s, p, k, v});
	endtask : probe

	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		complete_run();
	end

	initial begin
		mismatches  = 0;
		comparisons = 0;
		rst_n    = 1'b0;
		regWr    = 1'b0;
		regRd    = 1'b0;
		regAddr  = 12'h000;
		regWdata = 32'h0000_0000;
		img0Base = 32'h0000_3000;
		img0Ctrl = CTRL_RESET;
		repeat (16) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		for (i = 0; i < 10; i++) begin
			reg_rd(OFFS[i], (MSKS[i] == CTRL_MASK) ? CTRL_RESET : ADDR_RESET);
			reg_wr(OFFS[i], 32'hffff_ffff);
			reg_rd(OFFS[i], MSKS[i]);
		end
		reg_wr(12'h124, 32'hffff_ffff);
		reg_rd(12'h124, 32'h0000_0000);
		reg_wr(OFF_IMG0_BOUND, 32'h0000_5fff);
		reg_wr(OFF_IMG0_XLATE, 32'h0000_1000);
		reg_wr(OFF_IMG1_CTRL, 32'h8080_0000);
		reg_wr(OFF_IMG1_BASE, 32'h0010_ffff);
		reg_wr(OFF_IMG1_BOUND, 32'h0020_ffff);
		reg_wr(OFF_IMG1_XLATE, 32'hfff0_ffff);
		reg_wr(OFF_IMG2_CTRL, CTRL_RESET);
		reg_wr(OFF_IMG2_BASE, 32'h0040_0000);
		reg_wr(OFF_IMG2_BOUND, 32'h0050_0000);
		reg_wr(OFF_IMG2_XLATE, 32'h0000_0000);
		probe(32'h0000_3004, 1'b0, 1'b0, 2'h0, 32'h0, 1'b0, SGL);
		img0Ctrl = 32'h8080_0000;
		probe(32'h0000_2fff, 1'b0, 1'b0, 2'h0, 32'h0, 1'b0, SGL);
		probe(32'h0000_3004, 1'b0, 1'b1, 2'h0, 32'h0000_4004, 1'b0, SGL);
		probe(32'h0000_4fff, 1'b0, 1'b1, 2'h0, 32'h0000_5fff, 1'b0, SGL);
		probe(32'h0000_5000, 1'b0, 1'b0, 2'h0, 32'h0, 1'b0, SGL);
		probe(32'h0010_0000, 1'b0, 1'b1, 2'h1, 32'h0000_0000, 1'b0, SGL);
		probe(32'h001f_fffc, 1'b0, 1'b1, 2'h1, 32'h000f_fffc, 1'b0, SGL);
		probe(32'h0020_0000, 1'b0, 1'b0, 2'h0, 32'h0, 1'b0, SGL);
		probe(32'h0010_0000, 1'b1, 1'b0, 2'h0, 32'h0, 1'b0, SGL);
		reg_wr(OFF_IMG1_CTRL, CTRL_RESET);
		probe(32'h0010_0000, 1'b0, 1'b0, 2'h0, 32'h0, 1'b0, SGL);
		reg_wr(OFF_IMG2_CTRL, 32'hc080_0001);
		probe(32'h0040_0010, 1'b1, 1'b1, 2'h2, 32'h0040_0010, 1'b0, SGL);
		probe(32'h0040_0010, 1'b0, 1'b0, 2'h0, 32'h0, 1'b0, SGL);
		reg_wr(OFF_IMG2_CTRL, 32'hc080_0000);
		probe(32'h0040_0010, 1'b0, 1'b1, 2'h2, 32'h0040_0010, 1'b1, SGL);
		reg_wr(OFF_IMG2_CTRL, 32'h8080_0000);
		probe(32'h0040_0010, 1'b0, 1'b1, 2'h2, 32'h0040_0010, 1'b0, SGL);
		// every width and space code, with the cycle-type bit toggling across them
		for (i = 0; i < 32; i++) begin
			ctl = {1'b1, 7'h0, i[1:0], 3'h0, i[4:2], 1'b0, i[0], 1'b0, i[1], 3'h0, ^i[4:0], 8'h0};
			kind = (i[4:2] == SPACE_A24 || i[4:2] == SPACE_A32) ? ((i[1:0] == WIDTH_D64) ?
				PTID_XF_MBLT : (^i[4:0] ? PTID_XF_BLT : PTID_XF_SINGLE)) : PTID_XF_SINGLE;
			reg_wr(OFF_IMG2_CTRL, ctl);
			probe(32'h0040_0010, 1'b0, 1'b1, 2'h2, 32'h0040_0010, 1'b0, kind);
			check({56'h0, spaceBad, superAm, programAm, vmeSpace, vmeWidth}, {56'h0,
				(i[4:2] == 3'h3 || i[4:2] == 3'h4), i[1], i[0], i[4:2], i[1:0]});
		end
		reg_wr(OFF_IMG1_CTRL, 32'h8085_0000);
		probe(32'h0010_0000, 1'b0, 1'b1, 2'h1, 32'h0000_0000, 1'b0, SGL);
		check({63'h0, spaceBad}, {63'h0, 1'b1});
		reg_wr(OFF_IMG1_CTRL, 32'h8080_0000);
		reg_wr(OFF_IMG1_BOUND, 32'h0000_0000);
		probe(32'hfff0_0000, 1'b0, 1'b1, 2'h1, 32'hffe0_0000, 1'b0, SGL);
		complete_run();
	end
endmodule : tb
`default_nettype wire
